// ### core_defs.svh
`ifndef CORE_DEFS_SVH
`define CORE_DEFS_SVH

// ****************************************
// Program counter and stack
// ****************************************
`define PC_WIDTH        11
`define RESET_VECTOR    11'h000
`define IRQ_VECTOR      11'h001
`define PAGE_SIZE       256
`define PAGE_COUNT      8
`define STACK_DEPTH     6
`define STACK_DEPTH_W   3'h6
`define STACK_LAST_IDX  3'h5

// ****************************************
// Status register layout
// ****************************************
`define STATUS_REG_INDEX 8'h03
`define STATUS_BYTE_ADDR (`STATUS_REG_INDEX << 2)
`define STATUS_RESET     8'h00
`define STATUS_WR_MASK   8'he7
`define STATUS_FLAG_MASK 8'h07
`define BIT_CARRY        0
`define BIT_NIBBLE_CARRY 1
`define BIT_ZERO         2
`define BIT_SLEEP_CAUSE  3
`define BIT_TIMEOUT_CAUSE 4
`define BIT_RAM_BANK     5

// ****************************************
// Bus answers
// ****************************************
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ### core_pkg.sv
package core_pkg;

  typedef enum logic [19:0] {
    OP_NOP   = 20'h00001,
    OP_ADD   = 20'h00002,
    OP_SUB   = 20'h00004,
    OP_AND   = 20'h00008,
    OP_IOR   = 20'h00010,
    OP_XOR   = 20'h00020,
    OP_RLF   = 20'h00040,
    OP_RRF   = 20'h00080,
    OP_INC   = 20'h00100,
    OP_DEC   = 20'h00200,
    OP_COM   = 20'h00400,
    OP_MOV   = 20'h00800,
    OP_STORE = 20'h01000,
    OP_BCLR  = 20'h02000,
    OP_BSET  = 20'h04000,
    OP_CALL  = 20'h08000,
    OP_GOTO  = 20'h10000,
    OP_RETURN     = 20'h20000,
    OP_RETURN_IRQ = 20'h40000,
    OP_RETURN_LIT = 20'h80000
  } op_e;

  // One decoded instruction handed to the datapath
  typedef struct packed {
    op_e         op;
    logic [10:0] target;
    logic [7:0]  literal;
    logic [7:0]  file_data;
    logic        use_literal;
    logic        dest_file;
    logic        file_is_status;
    logic        file_is_pcl;
    logic [2:0]  bit_index;
  } cmd_s;

  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       nib;
    logic       z;
    logic       fc;
    logic       fdc;
    logic       fz;
  } alu_s;

endpackage

// ### cpu_pc_stack_alu_status.sv
// Overview of operation
// - Program counter eleven bits, 2K words
// - Counter advances by one per instruction
// - Reset loads 000h, interrupt loads 001h
// - Call and jump take eleven-bit target
// - Returns restore counter from stack top, pop
// - Low-byte writes keep upper three bits
// - Upper three bits form page of 256
// - Stack holds six eleven-bit entries
// - Call and interrupt push return address
// - Eight-bit ALU: add, sub, shift, logic
// - Two operands: working register plus file/literal
// - Single operand: file or literal, result to working register or file
// - Subtract carries hold inverted borrows
// - Status writable like a data register, except read-only cause bits three and four
// - Flag-affecting writes to status drop flags
// - Status bit five selects RAM bank
// - Nibble carry: add carry, subtract no-borrow
// - Interrupt injects call 001h, blocks nesting
// - Bank bit at address 03h bit five
`include "core_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module cpu_pc_stack_alu_status
  import core_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Register bus
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Instruction stream
  input  wire logic        exec_valid,
  input  wire cmd_s        exec_cmd,
  input  wire logic        irq_request,
  // Reset-cause events
  input  wire logic        timeout_event,
  input  wire logic        sleep_event,
  input  wire logic        cause_clear_event,
  // Program ROM and data memory side
  output logic [10:0]      rom_addr,
  output logic [7:0]       w_value,
  output logic             file_write,
  output logic [7:0]       file_write_data,
  output logic             ram_bank_select,
  output logic             irq_taken,
  output logic             irq_blocked,
  output logic [2:0]       stack_depth
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [2:0] wrap_inc(input logic [2:0] i);
    wrap_inc = (i == `STACK_LAST_IDX) ? 3'h0 : i + 3'h1;
  endfunction

  function automatic logic [2:0] wrap_dec(input logic [2:0] i);
    wrap_dec = (i == 3'h0) ? `STACK_LAST_IDX : i - 3'h1;
  endfunction

  function automatic alu_s alu(input op_e op, input logic [7:0] a,
                               input logic [7:0] w, input logic cin);
    alu_s r;
    logic [8:0] s;
    r = '0;
    s = 9'h000;
    case (op)
      OP_ADD: begin
        s = {1'b0, a} + {1'b0, w};
        r.res = s[7:0];
        r.c = s[8];
        r.nib = ({1'b0, a[3:0]} + {1'b0, w[3:0]}) > 5'h0f;
        {r.fc, r.fdc} = 2'b11;
      end
      OP_SUB: begin
        r.res = a - w;
        r.c = (a >= w);
        r.nib = (a[3:0] >= w[3:0]);
        {r.fc, r.fdc} = 2'b11;
      end
      OP_AND: r.res = a & w;
      OP_IOR: r.res = a | w;
      OP_XOR: r.res = a ^ w;
      // Shifts go through carry and leave zero alone
      OP_RLF: begin
        {r.c, r.res} = {a, cin};
        r.fc = 1'b1;
      end
      OP_RRF: begin
        {r.res, r.c} = {cin, a};
        r.fc = 1'b1;
      end
      OP_INC: r.res = a + 8'h01;
      OP_DEC: r.res = a - 8'h01;
      OP_COM: r.res = ~a;
      OP_MOV: r.res = a;
      default: r.res = a;
    endcase
    r.fz = |(op & (OP_ADD | OP_SUB | OP_AND | OP_IOR | OP_XOR |
                   OP_INC | OP_DEC | OP_COM | OP_MOV));
    r.z = (r.res == 8'h00);
    alu = r;
  endfunction

  // ****************************************
  // Core state
  // ****************************************
  logic [10:0] pc_reg, pc_next;
  logic [10:0] stack_reg [`STACK_DEPTH];
  logic [10:0] stack_next [`STACK_DEPTH];
  logic [2:0]  top_reg, top_next;
  logic [2:0]  depth_reg, depth_next;
  logic [7:0]  w_reg, w_next;
  logic [7:0]  status_reg, status_next;
  logic        iflag_reg, iflag_next;
  logic        irq_return_seen_reg, irq_return_seen_next;
  logic        fwr_reg, fwr_next;
  logic [7:0]  fdata_reg, fdata_next;
  logic        taken_reg, taken_next;
  logic        bus_status_wr;
  logic [7:0]  operand;
  logic [7:0]  written;
  logic        accept;
  logic        is_return;
  logic        push;
  logic [10:0] push_addr;
  alu_s        a_out;

  // Second operand is file or literal
  assign operand = exec_cmd.use_literal ? exec_cmd.literal
                                        : exec_cmd.file_data;
  assign a_out = alu(exec_cmd.op, operand, w_reg,
                     status_reg[`BIT_CARRY]);
  assign is_return = |(exec_cmd.op & (OP_RETURN | OP_RETURN_IRQ |
                                      OP_RETURN_LIT));
  // Accept at instruction end unless blocked
  // A call defers acceptance to keep one push per cycle
  assign accept = exec_valid & irq_request & ~iflag_reg &
                  (exec_cmd.op != OP_CALL);

  always_comb begin
    written = a_out.res;
    case (exec_cmd.op)
      OP_STORE: written = w_reg;
      OP_BCLR:  written = operand & ~(8'h01 << exec_cmd.bit_index);
      OP_BSET:  written = operand | (8'h01 << exec_cmd.bit_index);
      default:  written = a_out.res;
    endcase
  end

  always_comb begin
    pc_next = pc_reg;
    stack_next = stack_reg;
    top_next = top_reg;
    depth_next = depth_reg;
    w_next = w_reg;
    status_next = status_reg;
    iflag_next = iflag_reg;
    irq_return_seen_next = irq_return_seen_reg;
    fwr_next = 1'b0;
    fdata_next = fdata_reg;
    taken_next = 1'b0;
    push = 1'b0;
    push_addr = pc_reg + 11'h001;
    if (bus_status_wr) begin
      status_next = (status_next & ~`STATUS_WR_MASK) |
                    (wbyte_reg & `STATUS_WR_MASK);
    end
    if (exec_valid) begin
      pc_next = pc_reg + 11'h001;
      if (irq_return_seen_reg) begin
        iflag_next = 1'b0;
        irq_return_seen_next = 1'b0;
      end
      case (exec_cmd.op)
        OP_GOTO: pc_next = exec_cmd.target;
        OP_CALL: begin
          push = 1'b1;
          pc_next = exec_cmd.target;
        end
        OP_RETURN, OP_RETURN_IRQ, OP_RETURN_LIT: begin
          pc_next = stack_reg[wrap_dec(top_reg)];
          top_next = wrap_dec(top_reg);
          depth_next = (depth_reg == 3'h0) ? 3'h0 : depth_reg - 3'h1;
          if (exec_cmd.op == OP_RETURN_LIT)
            w_next = exec_cmd.literal;
          if (exec_cmd.op == OP_RETURN_IRQ)
            irq_return_seen_next = 1'b1;
        end
        OP_NOP: ;
        default: begin
          if (!exec_cmd.dest_file) begin
            w_next = written;
          end else begin
            fwr_next = 1'b1;
            fdata_next = written;
            if (exec_cmd.file_is_pcl)
              pc_next = {pc_reg[10:8], written};
            if (exec_cmd.file_is_status) begin
              if (a_out.fc | a_out.fdc | a_out.fz)
                status_next = (status_next & ~`STATUS_WR_MASK) |
                  (written & `STATUS_WR_MASK & ~`STATUS_FLAG_MASK) |
                  (status_next & `STATUS_FLAG_MASK);
              else
                status_next = (status_next & ~`STATUS_WR_MASK) |
                              (written & `STATUS_WR_MASK);
            end
          end
          if (a_out.fc)
            status_next[`BIT_CARRY] = a_out.c;
          if (a_out.fdc)
            status_next[`BIT_NIBBLE_CARRY] = a_out.nib;
          if (a_out.fz)
            status_next[`BIT_ZERO] = a_out.z;
        end
      endcase
      if (accept) begin
        push = 1'b1;
        push_addr = pc_next;
        pc_next = `IRQ_VECTOR;
        iflag_next = 1'b1;
        taken_next = 1'b1;
      end
      // Six entries, oldest overwritten when full
      if (push) begin
        // Builds on any pop of this cycle, so return plus irq nets zero
        stack_next[top_next] = push_addr;
        top_next = wrap_inc(top_next);
        if (depth_next != `STACK_DEPTH_W)
          depth_next = depth_next + 3'h1;
      end
    end
    // Cause events, set wins over clear
    if (cause_clear_event) begin
      status_next[`BIT_TIMEOUT_CAUSE] = 1'b0;
      status_next[`BIT_SLEEP_CAUSE] = 1'b0;
    end
    if (timeout_event)
      status_next[`BIT_TIMEOUT_CAUSE] = 1'b1;
    if (sleep_event)
      status_next[`BIT_SLEEP_CAUSE] = 1'b1;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pc_reg <= `RESET_VECTOR;
      for (int i = 0; i < `STACK_DEPTH; i++)
        stack_reg[i] <= 11'h000;
      top_reg <= 3'h0;
      depth_reg <= 3'h0;
      w_reg <= 8'h00;
      status_reg <= `STATUS_RESET;
      iflag_reg <= 1'b0;
      irq_return_seen_reg <= 1'b0;
      fwr_reg <= 1'b0;
      fdata_reg <= 8'h00;
      taken_reg <= 1'b0;
    end else begin
      pc_reg <= pc_next;
      stack_reg <= stack_next;
      top_reg <= top_next;
      depth_reg <= depth_next;
      w_reg <= w_next;
      status_reg <= status_next;
      iflag_reg <= iflag_next;
      irq_return_seen_reg <= irq_return_seen_next;
      fwr_reg <= fwr_next;
      fdata_reg <= fdata_next;
      taken_reg <= taken_next;
    end
  end

  assign rom_addr = pc_reg;
  assign w_value = w_reg;
  assign file_write = fwr_reg;
  assign file_write_data = fdata_reg;
  assign ram_bank_select = status_reg[`BIT_RAM_BANK];
  assign irq_taken = taken_reg;
  assign irq_blocked = iflag_reg;
  assign stack_depth = depth_reg;

  // ****************************************
  // Register bus slave
  // ****************************************
  logic       aw_got_reg, aw_got_next;
  logic       w_got_reg, w_got_next;
  logic [7:0] waddr_reg, waddr_next;
  logic [7:0] wbyte_reg, wbyte_next;
  logic       wlane_reg, wlane_next;
  logic       bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic       rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic       wr_fire;

  assign awready = ~aw_got_reg & ~bvalid_reg;
  assign wready = ~w_got_reg & ~bvalid_reg;
  assign arready = ~rvalid_reg;
  assign wr_fire = aw_got_reg & w_got_reg & ~bvalid_reg;
  assign bus_status_wr = wr_fire & wlane_reg &
                         (waddr_reg == `STATUS_BYTE_ADDR);

  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    waddr_next = waddr_reg;
    wbyte_next = wbyte_reg;
    wlane_next = wlane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (awvalid && awready) begin
      aw_got_next = 1'b1;
      waddr_next = awaddr;
    end
    if (wvalid && wready) begin
      w_got_next = 1'b1;
      wbyte_next = wdata[7:0];
      wlane_next = wstrb[0];
    end
    if (wr_fire) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (waddr_reg == `STATUS_BYTE_ADDR) ? `RESP_OKAY
                                                    : `RESP_SLVERR;
    end else if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_next = 1'b1;
      if (araddr == `STATUS_BYTE_ADDR) begin
        rdata_next = {24'h000000, status_reg};
        rresp_next = `RESP_OKAY;
      end else begin
        rdata_next = 32'h00000000;
        rresp_next = `RESP_SLVERR;
      end
    end else if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wbyte_reg <= 8'h00;
      wlane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RESP_OKAY;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      waddr_reg <= waddr_next;
      wbyte_reg <= wbyte_next;
      wlane_reg <= wlane_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_irq_vector_load: assert property (irq_taken
    |-> rom_addr == `IRQ_VECTOR && irq_blocked)
    else $error("interrupt did not load vector");
  a_pc_step_one: assert property (exec_valid && !accept
    && exec_cmd.op == OP_MOV && !exec_cmd.file_is_pcl
    |=> rom_addr == $past(rom_addr) + 11'h001)
    else $error("program counter did not advance");
  a_call_target: assert property (exec_valid
    && exec_cmd.op == OP_CALL |=> rom_addr == $past(exec_cmd.target))
    else $error("call target not loaded");
  a_pcl_keeps_page: assert property (exec_valid && !accept
    && exec_cmd.dest_file && exec_cmd.file_is_pcl
    && (exec_cmd.op == OP_MOV || exec_cmd.op == OP_STORE)
    |=> rom_addr[10:8] == $past(rom_addr[10:8]))
    else $error("page bits changed on low byte write");
  a_return_pop: assert property (exec_valid && is_return && !accept
    && depth_reg != 3'h0 |=> depth_reg == $past(depth_reg) - 3'h1)
    else $error("return did not pop");
  a_push_depth: assert property (exec_valid
    && exec_cmd.op == OP_CALL && depth_reg < 3'h5
    |=> depth_reg == $past(depth_reg) + 3'h1 ##1 depth_reg <= 3'h6)
    else $error("call did not push");
  a_depth_saturate: assert property (exec_valid
    && exec_cmd.op == OP_CALL && depth_reg == `STACK_DEPTH_W
    |=> depth_reg == `STACK_DEPTH_W)
    else $error("stack depth passed six");
  a_sub_borrow: assert property (exec_valid
    && exec_cmd.op == OP_SUB
    && !exec_cmd.file_is_status && !cause_clear_event
    |=> status_reg[0] == ($past(operand) >= $past(w_reg)))
    else $error("subtract carry wrong");
  a_cause_read_only: assert property (bus_status_wr && !exec_valid
    && !timeout_event && !sleep_event && !cause_clear_event
    |=> status_reg[4:3] == $past(status_reg[4:3]))
    else $error("cause bits written by software");
  a_bank_follows: assert property (exec_valid
    && exec_cmd.op == OP_BSET
    && exec_cmd.dest_file && exec_cmd.file_is_status
    && exec_cmd.bit_index == 3'h5 |=> ram_bank_select)
    else $error("bank select not set");
  a_no_nesting: assert property (irq_blocked
    |=> !irq_taken) else $error("nested interrupt accepted");

endmodule // cpu_pc_stack_alu_status

`default_nettype wire

// ### program_rom_model.sv
`timescale 1ns/1ns
`default_nettype none

module program_rom_model
  import core_pkg::*;
(
  // Fetch address and step request
  input  wire logic [10:0] rom_addr,
  input  wire logic        go,
  // Instruction handed to the core
  output logic             exec_valid,
  output var cmd_s         exec_cmd
);
  // ****************************************
  // Program store
  // ****************************************
  // 2K words, full counter
  cmd_s mem [2048];

  // Word follows the counter at once, so a jump is seen on the next step
  assign exec_valid = go;
  assign exec_cmd   = mem[rom_addr];
endmodule // program_rom_model

`default_nettype wire

// ### cpu_pc_stack_alu_status_tb.sv
`timescale 1ns/1ns
`default_nettype none

module cpu_pc_stack_alu_status_tb
  import core_pkg::*;
;
  logic        clock, arst_n, go, irq_request, exec_valid;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr, w_value, file_write_data;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        file_write, ram_bank_select, irq_taken, irq_blocked;
  logic        timeout_event, sleep_event, cause_clear_event;
  logic [10:0] rom_addr;
  logic [2:0]  stack_depth;
  cmd_s        exec_cmd;
  int          n_fail, num_checks;

  localparam logic [10:0] exp_pc [16] = '{11'h010, 11'h011, 11'h012,
    11'h013, 11'h123, 11'h014, 11'h015, 11'h016, 11'h001, 11'h200,
    11'h201, 11'h205, 11'h206, 11'h017, 11'h018, 11'h001};
  localparam logic [7:0] exp_w [16] = '{8'h00, 8'h0f, 8'h10, 8'hf5,
    8'hf5, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h05, 8'h05,
    8'h05, 8'h05, 8'h05};
  localparam logic [2:0] exp_dep [16] = '{3'h0, 3'h0, 3'h0, 3'h0,
    3'h1, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h0,
    3'h1};

  cpu_pc_stack_alu_status u_cpu_pc_stack_alu_status (
    .clock, .arst_n, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .exec_valid, .exec_cmd,
    .irq_request, .timeout_event, .sleep_event, .cause_clear_event,
    .rom_addr, .w_value, .file_write, .file_write_data, .ram_bank_select,
    .irq_taken, .irq_blocked, .stack_depth
  );

  program_rom_model u_program_rom_model (
    .rom_addr, .go, .exec_valid, .exec_cmd
  );

  always #50 clock = ~clock;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic cmd_s mk(input op_e op, input logic [10:0] t,
                              input logic [7:0] lit, input logic [7:0] fd,
                              input logic [3:0] f);
    cmd_s c;
    c = '{op, t, lit, fd, f[3], f[2], f[1], f[0], 3'h5};
    return c;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic reset_dut();
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] r);
    logic       ta, tw, ok;
    logic [1:0] resp;
    ok = 1'b0;
    resp = 2'h0;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // Only the watchdog ends a wait that never gets its answer
    while (!ok) begin
      @(negedge clock);
      ta = awready & awvalid;
      tw = wready & wvalid;
      ok = bvalid;
      resp = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (ok) bready <= 1'b0;
    end
    check(resp, r);
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] r);
    logic        ta, ok;
    logic [31:0] data;
    logic [1:0]  resp;
    ok = 1'b0;
    data = 32'h00000000;
    resp = 2'h0;
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!ok) begin
      @(negedge clock);
      ta = arready & arvalid;
      ok = rvalid;
      data = rdata;
      resp = rresp;
      @(posedge clock);
      if (ta) arvalid <= 1'b0;
      if (ok) rready <= 1'b0;
    end
    check(data, d);
    check(resp, r);
  endtask

  task automatic step(input logic irq, input logic [10:0] pc,
                      input logic [7:0] w, input logic [2:0] dep,
                      input logic tk);
    @(posedge clock);
    irq_request <= irq;
    go          <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(negedge clock);
    check(rom_addr, pc);
    check(w_value, w);
    check(stack_depth, dep);
    check(irq_taken, tk);
  endtask

  task automatic pulse_events(input logic [2:0] ev);
    @(posedge clock);
    {timeout_event, sleep_event, cause_clear_event} <= ev;
    @(posedge clock);
    {timeout_event, sleep_event, cause_clear_event} <= 3'h0;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    {go, irq_request, awvalid, wvalid, bready, arvalid, rready} = '0;
    {timeout_event, sleep_event, cause_clear_event} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    foreach (u_program_rom_model.mem[i])
      u_program_rom_model.mem[i] = mk(OP_NOP, '0, '0, '0, 4'h0);
    u_program_rom_model.mem[11'h000] = mk(OP_GOTO, 11'h010, '0, '0, 4'h0);
    u_program_rom_model.mem[11'h001] = mk(OP_GOTO, 11'h200, '0, '0, 4'h0);
    u_program_rom_model.mem[11'h010] = mk(OP_MOV, '0, 8'h0f, '0, 4'h8);
    u_program_rom_model.mem[11'h011] = mk(OP_ADD, '0, 8'h01, '0, 4'h8);
    u_program_rom_model.mem[11'h012] = mk(OP_SUB, '0, 8'h05, '0, 4'h8);
    u_program_rom_model.mem[11'h013] = mk(OP_CALL, 11'h123, '0, '0, 4'h0);
    u_program_rom_model.mem[11'h123] = mk(OP_RETURN_LIT, '0, 8'h55, '0, 4'h0);
    u_program_rom_model.mem[11'h014] = mk(OP_ADD, '0, 8'hab, '0, 4'h8);
    u_program_rom_model.mem[11'h015] = mk(OP_BSET, '0, '0, 8'h07, 4'h6);
    u_program_rom_model.mem[11'h200] = mk(OP_MOV, '0, 8'h05, '0, 4'h8);
    u_program_rom_model.mem[11'h201] = mk(OP_STORE, '0, '0, '0, 4'h5);
    u_program_rom_model.mem[11'h205] = mk(OP_ADD, '0, '0, 8'h23, 4'h6);
    u_program_rom_model.mem[11'h206] = mk(OP_RETURN_IRQ, '0, '0, '0, 4'h0);
    for (int i = 0; i < 7; i++)
      u_program_rom_model.mem[11'h020 + i] =
        mk(OP_CALL, 11'(11'h021 + i), '0, '0, 4'h0);
    u_program_rom_model.mem[11'h027] = mk(OP_RETURN, '0, '0, '0, 4'h0);
    reset_dut();
    check(rom_addr, 11'h000);
    axi_read(8'h0c, 32'h0, 2'h0);
    axi_write(8'h0c, 32'hff, 2'h0);
    axi_read(8'h0c, 32'he7, 2'h0);
    check(ram_bank_select, 1'b1);
    pulse_events(3'h6);
    axi_read(8'h0c, 32'hff, 2'h0);
    axi_write(8'h0c, 32'h0, 2'h0);
    axi_read(8'h0c, 32'h18, 2'h0);
    pulse_events(3'h1);
    axi_read(8'h0c, 32'h0, 2'h0);
    axi_write(8'h40, 32'h1, 2'h2);
    axi_read(8'h40, 32'h0, 2'h2);
    for (int i = 0; i < 16; i++) begin
      step(i >= 8, exp_pc[i], exp_w[i], exp_dep[i], i == 8 || i == 15);
      if (i == 7) check({file_write, file_write_data}, 9'h127);
      if (i == 10) check(file_write, 1'b0);
      if (i == 11) check({file_write, file_write_data}, 9'h105);
      if (i == 3) axi_read(8'h0c, 32'h02, 2'h0);
      if (i == 6) axi_read(8'h0c, 32'h07, 2'h0);
      if (i == 7) axi_read(8'h0c, 32'h27, 2'h0);
      if (i == 7) check(ram_bank_select, 1'b1);
      if (i == 12) axi_read(8'h0c, 32'h20, 2'h0);
    end
    check(irq_blocked, 1'b1);
    u_program_rom_model.mem[11'h000] = mk(OP_GOTO, 11'h020, '0, '0, 4'h0);
    reset_dut();
    check(rom_addr, 11'h000);
    check(stack_depth, 3'h0);
    step(1'b0, 11'h020, 8'h00, 3'h0, 1'b0);
    for (int i = 0; i < 7; i++)
      step(1'b0, 11'(11'h021 + i), 8'h00,
           3'((i < 5) ? i + 1 : 6), 1'b0);
    step(1'b0, 11'h027, 8'h00, 3'h5, 1'b0);
    step(1'b0, 11'h026, 8'h00, 3'h4, 1'b0);
    tally_and_finish();
  end

  // Whole run is under two hundred cycles
  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    tally_and_finish();
  end
endmodule // cpu_pc_stack_alu_status_tb

`default_nettype wire
